// ===== hw/bscan_consts.svh
// Constants of the boundary scan instruction control block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BSCAN_CONSTS_SVH
`define BSCAN_CONSTS_SVH

// Instruction register
`define BSCAN_IR_LEN        3
`define BSCAN_IR_EXTEST     3'h0
`define BSCAN_IR_SAMPLE     3'h1
`define BSCAN_IR_FLOAT      3'h4
`define BSCAN_IR_CLAMP      3'h5
`define BSCAN_IR_RESET      3'h7
`define BSCAN_IR_BYPASS_BIT 1

// Boundary scan register layout
`define BSCAN_BSR_LEN       196
`define BSCAN_NUM_BIDIR     168
`define BSCAN_NUM_GROUP     14
`define BSCAN_GROUP_SIZE    12
`define BSCAN_NUM_IN        8
`define BSCAN_NUM_OUT       6
`define BSCAN_POS_BIDIR     0
`define BSCAN_POS_CTL       168
`define BSCAN_POS_IN        182
`define BSCAN_POS_OUT       190

// Reset values and counts
`define BSCAN_TMS_ONES      3'h5
`define BSCAN_RST_BYPASS    1'h0
`define BSCAN_RST_TDO       1'h0
`define BSCAN_RST_TDO_OE_N  1'h1

`endif

// ===== hw/bscan_pkg.sv
// Types shared by the boundary scan instruction control files.
// Assumes bscan_consts.svh is on the include path.
`include "bscan_consts.svh"

package bscan_pkg;

  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_t;

  typedef enum logic [2:0] {
    kind_extest, kind_sample, kind_bypass, kind_float, kind_clamp
  } instr_kind_t;

  typedef struct packed {
    logic                        tms;
    logic                        tdi;
  } tap_link_t;

  typedef struct packed {
    logic [`BSCAN_NUM_BIDIR-1:0] data;
    logic [`BSCAN_NUM_BIDIR-1:0] oe_n;
  } bidir_drive_t;

  typedef struct packed {
    logic [`BSCAN_NUM_OUT-1:0]   data;
    logic [`BSCAN_NUM_OUT-1:0]   oe_n;
  } out_drive_t;

endpackage : bscan_pkg

// ===== hw/level_sync.sv
// Three-stage level synchroniser with agreement filter.
// Assumes a level that is slow against i_clock.
`include "bscan_consts.svh"

module level_sync #(
  parameter logic INIT = 1'h0
) (
  input  wire logic i_clock,   // Destination clock
  input  wire logic i_sys_rst, // Synchronous reset, active high
  input  wire logic i_level,   // Level from another domain
  output logic      o_level    // Filtered level
);
  import bscan_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end else begin
      s1_q  <= i_level;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (s2_q == s3_q) ? s3_q : out_q;
    end
  end

  assign o_level = out_q;

  a_sync_agree: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (s2_q == s3_q) |=> (out_q == $past(s3_q)))
    else $error("synchroniser output missed agreed level");

endmodule : level_sync

// ===== hw/boundary_chain.sv
// Boundary scan shift chain with update latches.
// Assumes TCK-domain control strobes from the test controller.
`include "bscan_consts.svh"

module boundary_chain (
  input  wire logic                      i_tck,     // Test clock
  input  wire logic                      i_rst,     // Test logic reset, sync, active high
  input  wire logic                      i_capture, // Capture-DR with chain selected
  input  wire logic                      i_shift,   // Shift-DR with chain selected
  input  wire logic                      i_update,  // Update-DR with chain selected
  input  wire logic                      i_tdi,     // Serial data in
  input  wire logic [`BSCAN_BSR_LEN-1:0] i_capture_data, // Parallel capture values
  output logic                           o_tdo,     // Serial data out, bit 0
  output logic [`BSCAN_BSR_LEN-1:0]      o_update   // Latched cell values
);
  import bscan_pkg::*;

  logic [`BSCAN_BSR_LEN-1:0] shift_q;
  logic [`BSCAN_BSR_LEN-1:0] shift_d;
  logic [`BSCAN_BSR_LEN-1:0] upd_q;

  genvar i;
  generate
    for (i = 0; i < `BSCAN_BSR_LEN; i++) begin : g_cell
      wire logic next_in = (i == `BSCAN_BSR_LEN - 1) ? i_tdi : shift_q[(i + 1) % `BSCAN_BSR_LEN];
      assign shift_d[i] = i_capture ? i_capture_data[i] : (i_shift ? next_in : shift_q[i]);
    end
  endgenerate

  always_ff @(posedge i_tck) begin
    if (i_rst) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge i_tck) begin
    if (i_rst) begin
      upd_q <= '0;
    end else if (i_update) begin
      upd_q <= shift_q;
    end
  end

  assign o_tdo    = shift_q[0];
  assign o_update = upd_q;

  a_update_hold: assert property (@(posedge i_tck) disable iff (i_rst)
    !i_update |=> $stable(upd_q))
    else $error("boundary update latch changed outside update");

endmodule : boundary_chain

// ===== hw/boundary_scan_instruction_control.sv
// Test access port controller, instruction register and pin control.
// Assumes TCK from the tester, a free system clock and pads outside.
`include "bscan_consts.svh"

module boundary_scan_instruction_control (
  input  wire logic                        i_clock,       // System clock, 10 MHz
  input  wire logic                        i_sys_rst,     // System reset, sync, active high
  input  wire logic                        i_por,         // Power-on reset, active high
  input  wire logic                        i_tck,         // Test clock from tester
  input  wire logic                        i_trst_n,      // Test reset, active low
  input  wire bscan_pkg::tap_link_t        i_link,        // TMS and TDI from tester
  output logic                             o_tdo,         // Serial test data out
  output logic                             o_tdo_oe_n,    // TDO drive enable, active low
  input  wire logic                        i_three_state_all_pin_n, // Float request pin, active low
  input  wire logic                        i_stop_request, // Core asks for low-power stop
  output logic                             o_low_power_stop, // Stop mode granted
  output logic                             o_core_reset,  // Reset to core logic
  input  wire bscan_pkg::bidir_drive_t     i_core_bidir,  // Core drive of bidir pins
  output logic [`BSCAN_NUM_BIDIR-1:0]      o_core_bidir_in, // Bidir pin levels to core
  input  wire bscan_pkg::out_drive_t       i_core_out,    // Core drive of output pins
  output logic [`BSCAN_NUM_IN-1:0]         o_core_in,     // Input pin levels to core
  output bscan_pkg::bidir_drive_t          o_pad_bidir,   // Bidir pad drive
  input  wire logic [`BSCAN_NUM_BIDIR-1:0] i_pad_bidir,   // Bidir pad levels
  output bscan_pkg::out_drive_t            o_pad_out,     // Output pad drive
  input  wire logic [`BSCAN_NUM_IN-1:0]    i_pad_in       // Input pad levels
);
  import bscan_pkg::*;

  // ****************************************************************
  // Test controller
  // ****************************************************************

  tap_state_t                 state_q;
  tap_state_t                 state_d;
  logic [2:0]                 tms_ones_q;
  wire logic                  tap_rst = i_por | ~i_trst_n;

  always_comb begin
    unique case (state_q)
      st_reset:    state_d = i_link.tms ? st_reset    : st_idle;
      st_idle:     state_d = i_link.tms ? st_sel_dr   : st_idle;
      st_sel_dr:   state_d = i_link.tms ? st_sel_ir   : st_cap_dr;
      st_cap_dr:   state_d = i_link.tms ? st_exit1_dr : st_shift_dr;
      st_shift_dr: state_d = i_link.tms ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: state_d = i_link.tms ? st_upd_dr   : st_pause_dr;
      st_pause_dr: state_d = i_link.tms ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: state_d = i_link.tms ? st_upd_dr   : st_shift_dr;
      st_upd_dr:   state_d = i_link.tms ? st_sel_dr   : st_idle;
      st_sel_ir:   state_d = i_link.tms ? st_reset    : st_cap_ir;
      st_cap_ir:   state_d = i_link.tms ? st_exit1_ir : st_shift_ir;
      st_shift_ir: state_d = i_link.tms ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: state_d = i_link.tms ? st_upd_ir   : st_pause_ir;
      st_pause_ir: state_d = i_link.tms ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: state_d = i_link.tms ? st_upd_ir   : st_shift_ir;
      st_upd_ir:   state_d = i_link.tms ? st_sel_dr   : st_idle;
    endcase
  end

  // TCK runs ungated in stop mode, so the controller keeps stepping
  always_ff @(posedge i_tck) begin
    if (tap_rst) begin
      state_q <= st_reset;
    end else begin
      state_q <= state_d;
    end
  end

  // Consecutive TMS ones, saturating
  always_ff @(posedge i_tck) begin
    if (tap_rst) begin
      tms_ones_q <= 3'h0;
    end else if (!i_link.tms) begin
      tms_ones_q <= 3'h0;
    end else if (tms_ones_q != `BSCAN_TMS_ONES) begin
      tms_ones_q <= tms_ones_q + 3'h1;
    end
  end

  wire logic in_reset   = (state_q == st_reset);
  wire logic cap_ir     = (state_q == st_cap_ir);
  wire logic shift_ir   = (state_q == st_shift_ir);
  wire logic upd_ir     = (state_q == st_upd_ir);
  wire logic cap_dr     = (state_q == st_cap_dr);
  wire logic shift_dr   = (state_q == st_shift_dr);
  wire logic upd_dr     = (state_q == st_upd_dr);

  // ****************************************************************
  // Instruction register
  // ****************************************************************

  logic [`BSCAN_IR_LEN-1:0]   ir_sr_q;
  logic [`BSCAN_IR_LEN-1:0]   ir_q;

  wire logic [`BSCAN_IR_LEN-1:0] ir_sr_d =
    cap_ir   ? `BSCAN_IR_CLAMP :
    shift_ir ? {i_link.tdi, ir_sr_q[`BSCAN_IR_LEN-1:1]} :
               ir_sr_q;

  always_ff @(posedge i_tck) begin
    if (tap_rst) begin
      ir_sr_q <= `BSCAN_IR_RESET;
    end else begin
      ir_sr_q <= ir_sr_d;
    end
  end

  always_ff @(posedge i_tck) begin
    if (tap_rst || in_reset) begin
      ir_q <= `BSCAN_IR_RESET;
    end else if (upd_ir) begin
      ir_q <= ir_sr_q;
    end
  end

  // ****************************************************************
  // Instruction decode
  // ****************************************************************

  wire logic is_extest = (ir_q == `BSCAN_IR_EXTEST);
  wire logic is_sample = (ir_q == `BSCAN_IR_SAMPLE);
  wire logic is_bypass = ir_q[`BSCAN_IR_BYPASS_BIT];
  wire logic is_float  = (ir_q == `BSCAN_IR_FLOAT);
  wire logic is_clamp  = (ir_q == `BSCAN_IR_CLAMP);

  wire instr_kind_t kind =
    is_bypass ? kind_bypass :
    is_extest ? kind_extest :
    is_sample ? kind_sample :
    is_float  ? kind_float  :
                kind_clamp;

  // Chain selected for extest and sample/preload; all else uses bypass
  wire logic chain_sel  = (kind == kind_extest) || (kind == kind_sample);
  wire logic test_drive = (kind == kind_extest) || (kind == kind_clamp);

  // ****************************************************************
  // Bypass stage and boundary chain
  // ****************************************************************

  logic                       bypass_q;
  logic                       bsr_tdo;
  logic [`BSCAN_BSR_LEN-1:0]  bsr_cap;
  logic [`BSCAN_BSR_LEN-1:0]  bsr_upd;

  always_ff @(posedge i_tck) begin
    if (tap_rst) begin
      bypass_q <= `BSCAN_RST_BYPASS;
    end else if (cap_dr && !chain_sel) begin
      bypass_q <= 1'h0;
    end else if (shift_dr && !chain_sel) begin
      bypass_q <= i_link.tdi;
    end
  end

  boundary_chain u_chain (
    .i_tck          (i_tck),
    .i_rst          (tap_rst),
    .i_capture      (cap_dr && chain_sel),
    .i_shift        (shift_dr && chain_sel),
    .i_update       (upd_dr && chain_sel),
    .i_tdi          (i_link.tdi),
    .i_capture_data (bsr_cap),
    .o_tdo          (bsr_tdo),
    .o_update       (bsr_upd)
  );

  // ****************************************************************
  // Serial output, falling edge
  // ****************************************************************

  logic                       tdo_q;
  logic                       tdo_oe_n_q;

  wire logic tdo_d =
    shift_ir ? ir_sr_q[0] :
    shift_dr ? (chain_sel ? bsr_tdo : bypass_q) :
               tdo_q;

  always_ff @(negedge i_tck) begin
    if (tap_rst) begin
      tdo_q      <= `BSCAN_RST_TDO;
      tdo_oe_n_q <= `BSCAN_RST_TDO_OE_N;
    end else begin
      tdo_q      <= tdo_d;
      tdo_oe_n_q <= ~(shift_ir | shift_dr);
    end
  end

  assign o_tdo      = tdo_q;
  assign o_tdo_oe_n = tdo_oe_n_q;

  // ****************************************************************
  // Flags handed to the system clock
  // ****************************************************************

  logic                       ext_flag_q;
  logic                       tlr_flag_q;

  always_ff @(posedge i_tck) begin
    if (tap_rst) begin
      ext_flag_q <= 1'h0;
      tlr_flag_q <= 1'h1;
    end else begin
      ext_flag_q <= (ir_q == `BSCAN_IR_EXTEST) && !in_reset && !upd_ir;
      tlr_flag_q <= (state_d == st_reset);
    end
  end

  logic                       ext_s;
  logic                       tlr_s;
  logic                       por_s;
  logic                       three_state_all_pin_n_s;

  level_sync #(.INIT(1'h0)) u_sync_ext (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_level   (ext_flag_q),
    .o_level   (ext_s)
  );

  level_sync #(.INIT(1'h1)) u_sync_tlr (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_level   (tlr_flag_q),
    .o_level   (tlr_s)
  );

  level_sync #(.INIT(1'h1)) u_sync_por (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_por),
    .o_level   (por_s)
  );

  level_sync #(.INIT(1'h1)) u_sync_three_state_all_pin (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_three_state_all_pin_n),
    .o_level   (three_state_all_pin_n_s)
  );

  // ****************************************************************
  // System clock side
  // ****************************************************************

  logic                       core_reset_q;
  logic                       stop_q;
  logic                       three_state_all_pin_float_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      core_reset_q <= 1'h1;
      stop_q       <= 1'h0;
      three_state_all_pin_float_q <= 1'h0;
    end else begin
      core_reset_q <= por_s | ext_s;
      stop_q       <= i_stop_request & tlr_s;
      three_state_all_pin_float_q <= core_reset_q & ~three_state_all_pin_n_s;
    end
  end

  assign o_core_reset     = core_reset_q;
  assign o_low_power_stop = stop_q;

  // ****************************************************************
  // Pin control
  // ****************************************************************

  wire logic float_all = (kind == kind_float) | three_state_all_pin_float_q;

  logic [`BSCAN_NUM_BIDIR-1:0] bidir_data;
  logic [`BSCAN_NUM_BIDIR-1:0] bidir_oe_n;
  logic [`BSCAN_NUM_OUT-1:0]   out_data;
  logic [`BSCAN_NUM_OUT-1:0]   out_oe_n;

  genvar g;
  generate
    for (g = 0; g < `BSCAN_NUM_BIDIR; g++) begin : g_bidir
      wire logic ctl = bsr_upd[`BSCAN_POS_CTL + g / `BSCAN_GROUP_SIZE];
      assign bidir_data[g] = test_drive ? bsr_upd[`BSCAN_POS_BIDIR + g] : i_core_bidir.data[g];
      assign bidir_oe_n[g] = float_all | (test_drive ? ~ctl : i_core_bidir.oe_n[g]);
      assign bsr_cap[`BSCAN_POS_BIDIR + g] = i_pad_bidir[g];
    end
    for (g = 0; g < `BSCAN_NUM_GROUP; g++) begin : g_ctl
      assign bsr_cap[`BSCAN_POS_CTL + g] = bsr_upd[`BSCAN_POS_CTL + g];
    end
    for (g = 0; g < `BSCAN_NUM_IN; g++) begin : g_in
      assign bsr_cap[`BSCAN_POS_IN + g] = i_pad_in[g];
    end
    for (g = 0; g < `BSCAN_NUM_OUT; g++) begin : g_out
      assign out_data[g] = test_drive ? bsr_upd[`BSCAN_POS_OUT + g] : i_core_out.data[g];
      assign out_oe_n[g] = float_all | (test_drive ? 1'h0 : i_core_out.oe_n[g]);
      assign bsr_cap[`BSCAN_POS_OUT + g] = bsr_upd[`BSCAN_POS_OUT + g];
    end
  endgenerate

  assign o_pad_bidir     = {bidir_data, bidir_oe_n};
  assign o_pad_out       = {out_data, out_oe_n};
  assign o_core_bidir_in = i_pad_bidir;
  assign o_core_in       = i_pad_in;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  a_tms_five_reset: assert property (@(posedge i_tck) disable iff (tap_rst)
    (tms_ones_q == `BSCAN_TMS_ONES) |-> in_reset)
    else $error("five TMS ones did not reach test-logic-reset");

  a_tms_high_stay: assert property (@(posedge i_tck) disable iff (tap_rst)
    (in_reset && i_link.tms) |=> in_reset)
    else $error("left test-logic-reset with TMS high");

  a_ir_preset_ones: assert property (@(posedge i_tck) disable iff (tap_rst)
    in_reset |=> (ir_q == `BSCAN_IR_RESET))
    else $error("instruction not preset to all ones");

  a_ir_capture_clamp: assert property (@(posedge i_tck) disable iff (tap_rst)
    cap_ir |=> (ir_sr_q == `BSCAN_IR_CLAMP))
    else $error("capture-IR did not load clamp code");

  a_ir_update_only: assert property (@(posedge i_tck) disable iff (tap_rst)
    (!upd_ir && !in_reset) |=> $stable(ir_q))
    else $error("instruction changed outside update-IR");

  a_bypass_zero: assert property (@(posedge i_tck) disable iff (tap_rst)
    (cap_dr && !chain_sel) |=> (bypass_q == 1'h0))
    else $error("bypass stage not cleared in capture-DR");

  a_chain_to_tdo: assert property (@(negedge i_tck) disable iff (tap_rst)
    (shift_dr && chain_sel) |-> ##0 (tdo_d == bsr_tdo) ##1 (tdo_q == $past(bsr_tdo)))
    else $error("boundary chain not on TDO in shift-DR");

  a_bypass_to_tdo: assert property (@(negedge i_tck) disable iff (tap_rst)
    (shift_dr && !chain_sel) |=> (tdo_q == $past(bypass_q)))
    else $error("bypass stage not on TDO in shift-DR");

  a_float_all_off: assert property (@(posedge i_tck) disable iff (tap_rst)
    is_float |-> (&o_pad_bidir.oe_n && &o_pad_out.oe_n && !chain_sel))
    else $error("float instruction left a driver on");

  a_clamp_from_chain: assert property (@(posedge i_tck) disable iff (tap_rst)
    (is_clamp && !float_all) |-> (o_pad_out.data == bsr_upd[`BSCAN_POS_OUT +: `BSCAN_NUM_OUT]
                                  && !chain_sel && o_pad_out.oe_n == '0))
    else $error("clamp pins not driven from chain");

  a_por_holds_tap: assert property (@(posedge i_tck)
    i_por |=> in_reset)
    else $error("controller left reset during power-on reset");

  a_extest_core_rst: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    ext_s |=> o_core_reset)
    else $error("core not held in reset under extest");

  a_stop_in_reset: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_low_power_stop |-> $past(tlr_s))
    else $error("stop granted outside test-logic-reset");

  c_extest_shift: cover property (@(posedge i_tck) disable iff (tap_rst)
    is_extest && shift_dr);

  c_clamp_active: cover property (@(posedge i_tck) disable iff (tap_rst)
    is_clamp && upd_dr);

  c_float_active: cover property (@(posedge i_tck) disable iff (tap_rst)
    is_float && shift_dr);

  c_stop_granted: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    o_low_power_stop);

endmodule : boundary_scan_instruction_control

// ===== test/jtag_tester.sv
// Board tester model that clocks the test access port.
// Assumes the block's serial output arrives on i_tdo.
module jtag_tester (
  input  wire logic           i_tdo,            // Serial data line from block
  output logic                o_tck,            // Test clock, 15 ns period
  output logic                o_trst_n,         // Test reset, held off
  output bscan_pkg::tap_link_t o_link           // Mode select and data
);
  timeunit 1ns;
  timeprecision 100ps;
  import bscan_pkg::*;

  // Clock stands low and lines sit at their pullups until the first step
  initial begin
    o_tck            = 1'h0;
    o_trst_n         = 1'h1;
    o_link           = 2'h3;
  end

  // One test clock cycle; data out is taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_link = '{tms: tms, tdi: tdi};
    #7.5;
    tdo   = i_tdo;
    o_tck = 1'h1;
    #7.5;
    o_tck = 1'h0;
  endtask : step
endmodule : jtag_tester

// ===== test/tb.sv
// Self-checking bench for the boundary scan instruction control block.
// Assumes the tester model in jtag_tester.sv and the design under hw/.
`include "bscan_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bscan_pkg::*;

  logic                        clk = 1'h0, sys_rst = 1'h1, por = 1'h1, stop_req = 1'h1, three_state_all_pin_n = 1'h1;
  logic                        tdo, tdo_oe_n, lps, core_rst, tck, trst_n, t;
  logic                        tdo_line;
  tap_link_t                   link;
  bidir_drive_t                core_bidir = '0, pad_bidir;
  out_drive_t                  core_out = '0, pad_out;
  logic [`BSCAN_NUM_BIDIR-1:0] pad_bidir_i = '0, core_bidir_in;
  logic [`BSCAN_NUM_IN-1:0]    pad_in = '0, core_in;
  logic [31:0]                 lfsr_q = 32'h2E1D;
  logic [2:0]                  codes [8] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h5, 3'h4, 3'h1, 3'h0};
  int                          errors = 0, comparisons = 0;

  always #50 clk = ~clk;

  // Released line shows the inverse so a late drive is caught
  assign tdo_line = tdo_oe_n ? ~tdo : tdo;

  jtag_tester jtag_tester_inst (.i_tdo(tdo_line), .o_tck(tck), .o_trst_n(trst_n), .o_link(link));
  boundary_scan_instruction_control boundary_scan_instruction_control_inst (
    .i_clock(clk), .i_sys_rst(sys_rst), .i_por(por), .i_tck(tck), .i_trst_n(trst_n),
    .i_link(link), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_three_state_all_pin_n(three_state_all_pin_n),
    .i_stop_request(stop_req), .o_low_power_stop(lps), .o_core_reset(core_rst),
    .i_core_bidir(core_bidir), .o_core_bidir_in(core_bidir_in), .i_core_out(core_out),
    .o_core_in(core_in), .o_pad_bidir(pad_bidir), .i_pad_bidir(pad_bidir_i),
    .o_pad_out(pad_out), .i_pad_in(pad_in));

  //****************************************
  // Helpers
  //****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int exp_len(input logic [2:0] c);
    return (c[2:1] == 2'h0) ? `BSCAN_BSR_LEN : 1;
  endfunction : exp_len

  function automatic logic pick(input int sel);
    return sel == 0 ? lps : sel == 1 ? core_rst : &pad_out.oe_n;
  endfunction : pick

  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [195:0] exp, input logic [195:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic sync();
    @(posedge clk);
    #5;
  endtask : sync

  task automatic wait_for(input int sel, input logic val);
    int n;
    for (n = 0; n < 40 && pick(sel) !== val; n++) sync();
    if (n == 40) begin
      errors++;
      $display("MISMATCH wait %0d expected %0h seen %0h", sel, val, pick(sel));
      give_verdict();
    end
  endtask : wait_for

  task automatic st(input logic tms, input logic tdi);
    jtag_tester_inst.step(tms, tdi, t);
  endtask : st

  task automatic rnd();
    lfsr_q = lfsr(lfsr_q);
    core_bidir = 336'({11{lfsr_q}});
    core_out = 12'(lfsr_q);
    pad_bidir_i = 168'({6{lfsr_q}});
    pad_in = 8'(lfsr_q >> 12);
  endtask : rnd

  task automatic ir(input logic [2:0] code);
    logic [2:0] cap;
    st(1, 0);
    st(1, 0);
    st(0, 0);
    st(0, 0);
    for (int i = 0; i < 3; i++) begin
      st(i == 2, code[i]);
      cap[i] = t;
    end
    st(1, 0);
    st(0, 0);
    chk("ir_capture", 3'h5, cap);
  endtask : ir

  task automatic dr(input int exp);
    int n;
    st(1, 0);
    st(0, 0);
    st(0, 0);
    #1;
    chk("tdo_oe_n", 0, tdo_oe_n);
    st(0, 0);
    if (exp == 1) chk("bypass_first", 0, t);
    for (n = 0; n < 200; n++) st(0, 0);
    st(0, 1);
    for (n = 1; n <= 200; n++) begin
      st(0, 0);
      if (t === 1'h1) break;
    end
    chk("dr_length", exp, n);
    st(1, 1);
    st(1, 0);
    st(0, 0);
  endtask : dr

  //****************************************
  // Main sequence
  //****************************************
  initial begin
    repeat (6) @(posedge clk);
    #5;
    sys_rst = 1'h0;
    repeat (4) st(0, 0);
    sync();
    por = 1'h0;
    wait_for(1, 1'h0);
    wait_for(0, 1'h1);
    for (int i = 0; i < 20; i++) begin
      lfsr_q = lfsr(lfsr_q);
      st(1, lfsr_q[0]);
    end
    sync();
    chk("stop_in_reset", 1, lps);
    st(0, 0);
    wait_for(0, 1'h0);
    foreach (codes[i]) begin
      sync();
      rnd();
      ir(codes[i]);
      sync();
      chk("core_in", {pad_in, pad_bidir_i}, {core_in, core_bidir_in});
      if (codes[i] == 3'h4) chk("float_oe", 1, &{pad_out.oe_n, pad_bidir.oe_n});
      if (codes[i] == 3'h5) chk("clamp_oe", 0, pad_out.oe_n);
      if (codes[i][1]) chk("bypass_pins", core_out, pad_out);
      if (codes[i] == 3'h0) begin
        st(0, 0);
        wait_for(1, 1'h1);
      end
      dr(exp_len(codes[i]));
      if (codes[i] == 3'h0) chk("extest_out", 12'h800, pad_out);
      if (codes[i] == 3'h0) chk("extest_bidir_oe", 1, &pad_bidir.oe_n);
    end
    repeat (5) st(1, 0);
    sync();
    wait_for(0, 1'h1);
    wait_for(1, 1'h0);
    chk("reset_pins", core_out, pad_out);
    por = 1'h1;
    three_state_all_pin_n = 1'h0;
    core_out.oe_n = '0;
    wait_for(2, 1'h1);
    sync();
    por = 1'h0;
    three_state_all_pin_n = 1'h1;
    wait_for(2, 1'h0);
    give_verdict();
  end
endmodule : tb
